// *** hw/srp_map.svh ***
// Constants for the switching regulator drive: codes, timing figures and cycle conversion
`ifndef SRP_MAP_SVH
`define SRP_MAP_SVH

`define SRP_CLK_MHZ          50
`define SRP_MODE_LOW         8'h01
`define SRP_MODE_MED         8'h02
`define SRP_MODE_HIGH        8'h03
`define SRP_FS_NOMINAL       2'h0
`define SRP_PERIOD_LOW_NS    20833
`define SRP_PERIOD_MED_NS    10417
`define SRP_PERIOD_HIGH_NS   2604
`define SRP_ONTIME_NOM_NS    1830
`define SRP_ONTIME_MAX_NS    1845
`define SRP_OFFSET_NS        1302
`define SRP_BLANK_NS         120
`define SRP_DUTY_LOW_PM      88
`define SRP_DUTY_MED_PM      176
`define SRP_DUTY_HIGH_PM     703
`define SRP_NS_TO_CYC_DN(ns) (((ns) * `SRP_CLK_MHZ) / 1000)
`define SRP_NS_TO_CYC_UP(ns) (((ns) * `SRP_CLK_MHZ + 999) / 1000)

`endif

// *** hw/srp_pkg.sv ***
// Types shared by the switching regulator drive modules
package srp_pkg;
    localparam int SRP_CNT_W = 11;

    typedef enum logic [2:0] {
        SRP_IDLE  = 3'b001,
        SRP_BLANK = 3'b010,
        SRP_ON    = 3'b100
    } srp_state_t;

    typedef struct packed {
        logic [SRP_CNT_W-1:0] period;
        logic [SRP_CNT_W-1:0] on_max;
        logic [SRP_CNT_W-1:0] offset;
        logic [SRP_CNT_W-1:0] blank;
    } srp_timing_t;
endpackage

// *** hw/srp_pulse.sv ***
// One gate-drive channel: blanking, maximum on-time and current-sense cut-off
`timescale 1ns/1ps
module srp_pulse (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        start,
    input  wire logic        kill,
    input  wire logic        sense,
    input  wire logic [10:0] blank_cyc,
    input  wire logic [10:0] on_cyc,
    output logic             drive
);
    srp_pkg::srp_state_t state_reg;
    srp_pkg::srp_state_t state_next;
    logic [10:0]         cnt_reg;
    logic [10:0]         cnt_next;
    logic                drive_reg;
    logic                drive_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            srp_pkg::SRP_IDLE: begin
                if (start && !kill) begin
                    state_next = srp_pkg::SRP_BLANK;
                    cnt_next   = 11'h001;
                end
            end
            srp_pkg::SRP_BLANK: begin
                if (kill || cnt_reg >= on_cyc) begin
                    state_next = srp_pkg::SRP_IDLE;
                end else if (cnt_reg >= blank_cyc) begin
                    state_next = srp_pkg::SRP_ON;
                end
                cnt_next = cnt_reg + 11'h001;
            end
            srp_pkg::SRP_ON: begin
                if (kill || sense || cnt_reg >= on_cyc) begin
                    state_next = srp_pkg::SRP_IDLE;
                end else begin
                    cnt_next = cnt_reg + 11'h001;
                end
            end
            default: begin
                state_next = srp_pkg::SRP_IDLE;
                cnt_next   = 11'h000;
            end
        endcase
        drive_next = (state_next != srp_pkg::SRP_IDLE);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= srp_pkg::SRP_IDLE;
            cnt_reg   <= 11'h000;
            drive_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            drive_reg <= drive_next;
        end
    end

    assign drive = drive_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_blank_hold: assert property ((state_reg == srp_pkg::SRP_BLANK) && !kill
        && (cnt_reg < on_cyc) |=> drive_reg)
        else $error("sense or timer ended pulse inside blanking");
    a_sense_cut: assert property ((state_reg == srp_pkg::SRP_ON) && sense |=> !drive_reg)
        else $error("over-current did not end the pulse");
    a_on_bound: assert property (drive_reg && !kill |-> (cnt_reg <= on_cyc))
        else $error("pulse ran past its maximum on-time");
endmodule

// *** hw/srp_drive.sv ***
// Top of the switching regulator drive: mode timing, period counter and two channels
`timescale 1ns/1ps
`include "srp_map.svh"
module srp_drive (
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic [7:0] POWER_MODE,
    input  wire logic [1:0] SWITCH_FREQ_SELECT,
    input  wire logic       PRIMARY_SWITCH_CURRENT_SENSE,
    output logic            PRIMARY_SWITCH_DRIVE,
    output logic            SECONDARY_SWITCH_DRIVE
);
    logic                 sense_s1_reg;
    logic                 sense_s2_reg;
    logic [7:0]           mode_reg;
    logic [1:0]           fs_reg;
    logic [10:0]          per_cnt_reg;
    logic [10:0]          per_cnt_next;
    logic                 mode_valid;
    logic                 cfg_change;
    logic                 kill;
    logic                 sec_start;
    logic                 pri_start;
    srp_pkg::srp_timing_t timing;

    function automatic logic [10:0] srp_scale(input logic [10:0] c, input logic [1:0] fs);
        logic [10:0] v;
        v = c >> fs;
        if (v == 11'h000) begin
            v = 11'h001;
        end
        return v;
    endfunction

    function automatic srp_pkg::srp_timing_t srp_timing(input logic [7:0] m,
                                                        input logic [1:0] fs);
        srp_pkg::srp_timing_t t;
        logic [10:0]          p;
        case (m)
            `SRP_MODE_LOW:  p = 11'(`SRP_NS_TO_CYC_DN(`SRP_PERIOD_LOW_NS));
            `SRP_MODE_MED:  p = 11'(`SRP_NS_TO_CYC_DN(`SRP_PERIOD_MED_NS));
            `SRP_MODE_HIGH: p = 11'(`SRP_NS_TO_CYC_DN(`SRP_PERIOD_HIGH_NS));
            default:        p = 11'h7ff;
        endcase
        t.period = srp_scale(p, fs);
        t.on_max = srp_scale(11'(`SRP_NS_TO_CYC_DN(`SRP_ONTIME_NOM_NS)), fs);
        t.offset = srp_scale(11'(`SRP_NS_TO_CYC_DN(`SRP_OFFSET_NS)), fs);
        t.blank  = srp_scale(11'(`SRP_NS_TO_CYC_UP(`SRP_BLANK_NS)), fs);
        return t;
    endfunction

    assign mode_valid = (POWER_MODE == `SRP_MODE_LOW) || (POWER_MODE == `SRP_MODE_MED)
                        || (POWER_MODE == `SRP_MODE_HIGH);
    assign cfg_change = (POWER_MODE != mode_reg) || (SWITCH_FREQ_SELECT != fs_reg);
    assign kill       = !mode_valid || cfg_change;
    assign timing     = srp_timing(POWER_MODE, SWITCH_FREQ_SELECT);

    always_comb begin
        if (kill) begin
            per_cnt_next = 11'h000;
        end else if (per_cnt_reg >= 11'(timing.period - 11'h001)) begin
            per_cnt_next = 11'h000;
        end else begin
            per_cnt_next = per_cnt_reg + 11'h001;
        end
    end

    assign sec_start = !kill && (per_cnt_reg == 11'h000);
    assign pri_start = !kill && (per_cnt_reg == timing.offset);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sense_s1_reg <= 1'b0;
            sense_s2_reg <= 1'b0;
            mode_reg     <= 8'h00;
            fs_reg       <= 2'h0;
            per_cnt_reg  <= 11'h000;
        end else begin
            sense_s1_reg <= PRIMARY_SWITCH_CURRENT_SENSE;
            sense_s2_reg <= sense_s1_reg;
            mode_reg     <= POWER_MODE;
            fs_reg       <= SWITCH_FREQ_SELECT;
            per_cnt_reg  <= per_cnt_next;
        end
    end

    srp_pulse u_secondary (
        .clk       (CLK),
        .nrst      (NRST),
        .start     (sec_start),
        .kill      (kill),
        .sense     (1'b0),
        .blank_cyc (timing.blank),
        .on_cyc    (timing.on_max),
        .drive     (SECONDARY_SWITCH_DRIVE)
    );

    srp_pulse u_primary (
        .clk       (CLK),
        .nrst      (NRST),
        .start     (pri_start),
        .kill      (kill),
        .sense     (sense_s2_reg),
        .blank_cyc (timing.blank),
        .on_cyc    (timing.on_max),
        .drive     (PRIMARY_SWITCH_DRIVE)
    );

    // Helper counters for checking
    logic        sec_d_reg;
    logic        pri_d_reg;
    logic        sec_rise;
    logic        pri_rise;
    logic [11:0] gap_reg;
    logic [11:0] pri_len_reg;
    logic        run_ok_reg;

    assign sec_rise = SECONDARY_SWITCH_DRIVE && !sec_d_reg;
    assign pri_rise = PRIMARY_SWITCH_DRIVE && !pri_d_reg;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sec_d_reg   <= 1'b0;
            pri_d_reg   <= 1'b0;
            gap_reg     <= 12'h000;
            pri_len_reg <= 12'h000;
            run_ok_reg  <= 1'b0;
        end else begin
            sec_d_reg   <= SECONDARY_SWITCH_DRIVE;
            pri_d_reg   <= PRIMARY_SWITCH_DRIVE;
            gap_reg     <= sec_rise ? 12'h001 : 12'(gap_reg + 12'h001);
            pri_len_reg <= PRIMARY_SWITCH_DRIVE ? 12'(pri_len_reg + 12'h001) : 12'h000;
            if (kill) begin
                run_ok_reg <= 1'b0;
            end else if (sec_rise) begin
                run_ok_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    a_period_low: assert property (sec_rise && run_ok_reg && !kill
        && mode_reg == `SRP_MODE_LOW && fs_reg == `SRP_FS_NOMINAL
        |-> gap_reg == 12'h411)
        else $error("low power period wrong");
    a_period_med: assert property (sec_rise && run_ok_reg && !kill
        && mode_reg == `SRP_MODE_MED && fs_reg == `SRP_FS_NOMINAL
        |-> gap_reg == 12'h208)
        else $error("medium power period wrong");
    a_period_high: assert property (sec_rise && run_ok_reg && !kill
        && mode_reg == `SRP_MODE_HIGH && fs_reg == `SRP_FS_NOMINAL
        |-> gap_reg == 12'h082)
        else $error("high power period wrong");
    a_ontime_max: assert property (PRIMARY_SWITCH_DRIVE |-> pri_len_reg < 12'h05c)
        else $error("primary on-time above limit");
    a_duty_limit: assert property (mode_valid && SWITCH_FREQ_SELECT == `SRP_FS_NOMINAL
        |-> timing.on_max * 1000 <= timing.period * ((POWER_MODE == `SRP_MODE_LOW)
        ? `SRP_DUTY_LOW_PM : (POWER_MODE == `SRP_MODE_MED) ? `SRP_DUTY_MED_PM
        : `SRP_DUTY_HIGH_PM))
        else $error("duty cycle limit exceeded");
    a_offset_yz: assert property (pri_rise && run_ok_reg && !kill
        && fs_reg == `SRP_FS_NOMINAL |-> gap_reg == 12'h041)
        else $error("secondary to primary offset wrong");
    a_scale_fs: assert property (sec_rise && run_ok_reg && !kill
        && mode_reg == `SRP_MODE_LOW && fs_reg == 2'h1 |-> gap_reg == 12'h208)
        else $error("frequency select did not scale period");
    a_off_invalid: assert property (!mode_valid |=> !PRIMARY_SWITCH_DRIVE
        && !SECONDARY_SWITCH_DRIVE)
        else $error("drive active with unknown power code");

    c_sense_cut: cover property (PRIMARY_SWITCH_DRIVE && sense_s2_reg ##1 !PRIMARY_SWITCH_DRIVE);
    c_high_both: cover property (mode_reg == `SRP_MODE_HIGH && PRIMARY_SWITCH_DRIVE
        && SECONDARY_SWITCH_DRIVE);
    c_fs_change: cover property (cfg_change && mode_valid ##1 !cfg_change ##1 sec_rise);
endmodule

// *** bench/srp_power_stage.sv ***
// Behavioural flyback power stage: with trip_en set, the current-sense pin rises once the primary drive has been high for trip_cyc cycles
`timescale 1ns/1ps
module srp_power_stage (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        drive,
    input  wire logic        trip_en,
    input  wire logic [31:0] trip_cyc,
    output logic             sense
);
    int on_reg;
    int on_next;

    always_comb begin
        on_next = drive ? on_reg + 1 : 0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            on_reg <= 0;
        end else begin
            on_reg <= on_next;
        end
    end

    // No switch current flows while the drive is off, so the sense resistor reads low
    assign sense = trip_en && drive && (on_reg >= trip_cyc);
endmodule

// *** bench/srp_drive_bench.sv ***
// Self-checking bench for the switching regulator drive
`timescale 1ns/1ps
`include "srp_map.svh"
module srp_drive_bench;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] mode = 8'h00;
    logic [1:0] fsel = 2'h0;
    logic       sense;
    logic       pri;
    logic       sec;
    logic       trip_en = 1'b0;
    int         trip_cyc = 0;
    int         fails = 0;
    int         comparisons = 0;

    always #10 clk = ~clk;

    srp_drive i_srp_drive (.CLK(clk), .NRST(nrst), .POWER_MODE(mode),
        .SWITCH_FREQ_SELECT(fsel), .PRIMARY_SWITCH_CURRENT_SENSE(sense),
        .PRIMARY_SWITCH_DRIVE(pri), .SECONDARY_SWITCH_DRIVE(sec));

    srp_power_stage i_srp_power_stage (.clk(clk), .nrst(nrst), .drive(pri),
        .trip_en(trip_en), .trip_cyc(trip_cyc), .sense(sense));

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check_count(input int got, input int lo, input int hi, input string what);
        comparisons++;
        if (got < lo || got > hi) begin
            fails++;
            $display("unexpected at %0t: %s is %0d", $time, what, got);
        end
    endtask

    task automatic check_low(input logic got, input string what);
        comparisons++;
        if (got !== 1'b0) begin
            fails++;
            $display("unexpected at %0t: %s not low", $time, what);
        end
    endtask

    function automatic logic pick(input bit p);
        return p ? pri : sec;
    endfunction

    // Steps until the chosen drive goes from low to high
    task automatic wait_rise(input bit p, output int n);
        logic last;
        n = 0;
        do begin
            last = pick(p);
            step();
            n++;
            if (n > 3000) begin
                fails++;
                $display("unexpected at %0t: no drive edge", $time);
                tally_and_finish();
            end
        end while (!(last === 1'b0 && pick(p) === 1'b1));
    endtask

    task automatic measure(input bit p, output int high, output int period);
        int n;
        wait_rise(p, n);
        high = 0;
        while (pick(p) === 1'b1 && high < 3000) begin
            step();
            high++;
        end
        wait_rise(p, n);
        period = high + n;
    endtask

    task automatic test_modes();
        int per[3] = '{1041, 520, 130};
        int pm[3] = '{`SRP_DUTY_LOW_PM, `SRP_DUTY_MED_PM, `SRP_DUTY_HIGH_PM};
        int h;
        int p;
        int n;
        for (int i = 0; i < 3; i++) begin
            mode = 8'h01 + 8'(i);
            measure(0, h, p);
            check_count(p, per[i], per[i], "period");
            check_count(h, 91, 92, "secondary on-time");
            check_count(int'(h * 1000 <= pm[i] * p), 1, 1, "duty");
            wait_rise(0, n);
            wait_rise(1, n);
            check_count(n, 65, 65, "offset");
            measure(1, h, p);
            check_count(h, 91, 92, "primary on-time");
        end
    endtask

    task automatic test_freq();
        int h;
        int p;
        int n;
        mode = `SRP_MODE_HIGH;
        for (int f = 1; f < 4; f++) begin
            fsel = 2'(f);
            measure(0, h, p);
            check_count(p, 130 >> f, 130 >> f, "scaled period");
            check_count(h, 91 >> f, 91 >> f, "scaled on-time");
            wait_rise(0, n);
            wait_rise(1, n);
            check_count(n, 65 >> f, 65 >> f, "scaled offset");
        end
        mode = `SRP_MODE_LOW;
        fsel = 2'h1;
        measure(0, h, p);
        check_count(p, 1041 >> 1, 1041 >> 1, "scaled low period");
        fsel = `SRP_FS_NOMINAL;
    endtask

    task automatic test_sense();
        int h;
        int p;
        mode = `SRP_MODE_HIGH;
        trip_en = 1'b1;
        trip_cyc = 1;
        measure(1, h, p);
        check_count(h, 7, 8, "blanked pulse");
        trip_cyc = 20;
        measure(1, h, p);
        check_count(h, 21, 25, "cut pulse");
        measure(0, h, p);
        check_count(h, 91, 92, "secondary with sense");
        trip_en = 1'b0;
    endtask

    task automatic test_off();
        logic [7:0] bad[4] = '{8'h00, 8'h04, 8'h80, 8'hff};
        for (int i = 0; i < 4; i++) begin
            mode = bad[i];
            step();
            repeat (300) begin
                step();
                check_low(pri | sec, "drive in off mode");
            end
        end
    endtask

    initial begin
        repeat (4) step();
        check_low(pri | sec, "drive in reset");
        nrst = 1'b1;
        test_modes();
        test_freq();
        test_sense();
        test_off();
        tally_and_finish();
    end
endmodule
